// File: design/adcss_top.sv
// Converter channel selection, completion status and result registers
// Function
// RQ1 - Five completion flags, one per channel, set when that channel's conversion ends.
// RQ2 - A completion flag clears when software writes a one to it, a zero leaves it.
// RQ3 - The end of a single cycle over all selected channels sets the single done flag.
// RQ4 - The end of a repeating pass over all selected channels sets the repeat done flag.
// RQ5 - A five-bit single mask picks the channels that a single cycle converts.
// RQ6 - A five-bit repeat mask picks the channels that each repeating pass converts.
// RQ7 - Each of the five channels has its own 32-bit result register.
// RQ8 - The result sits in the low ten bits and software cannot write it.
// RQ9 - The upper bits of every result register read as zero.
// RQ10 - Software reads a result in one 16- or 32-bit access, not as two byte reads.
// RQ11 - Software leaves the single mask alone while a cycle is running.
// RQ12 - Writing one to single start runs one cycle and the start bit clears itself.
// RQ13 - Start delay and repeat interval count 40 us units from 16-bit fields.
// RQ14 - The single done flag clears whenever a new single cycle begins.
// RQ15 - Setting repeat start begins passes over the channels of the repeat mask.
// RQ16 - A set completion flag stays set through later conversions until cleared.
// RQ17 - A result register is replaced whole at the end of its channel's conversion.
module adcss_top
   import adcss_pkg::*;
#(
   parameter int unsigned UNIT_CYC = ADCSS_UNIT_CYC
) (
   input  wire logic            core_clk,
   input  wire logic            rst,
   input  wire logic            ce,
   input  wire logic [5:0]      avs_address,
   input  wire logic            avs_read,
   input  wire logic            avs_write,
   input  wire logic [31:0]     avs_writedata,
   input  wire logic [3:0]      avs_byteenable,
   output logic      [31:0]     avs_readdata,
   output logic                 avs_waitrequest,
   output adcss_conv_req_t      conv_req,
   input  wire adcss_conv_res_t conv_res,
   output logic                 conv_power,
   output logic                 irq
);
   // Sequencer state
   adcss_state_t    state_reg, state_next;
   logic [2:0]      chan_reg, chan_next;
   logic [4:0]      pmask_reg, pmask_next;
   logic [15:0]     dcnt_reg, dcnt_next;
   adcss_conv_req_t req_reg, req_next;
   logic            psgl_reg, psgl_next;

   // Register state
   logic        act_reg, act_next;
   logic        sgl_reg, sgl_next;
   logic        rpt_reg, rpt_next;
   logic        pwd_reg, pwd_next;
   logic        srst_reg, srst_next;
   logic        rdone_reg, rdone_next;
   logic        sdone_reg, sdone_next;
   logic        pend_reg, pend_next;
   logic [31:0] dly_reg, dly_next;
   logic [4:0]  done_reg, done_next;
   logic [4:0]  smask_reg, smask_next;
   logic [4:0]  rmask_reg, rmask_next;
   logic [9:0]  res_reg [ADCSS_NCH];
   logic [9:0]  res_next [ADCSS_NCH];
   logic [2:0]  istat_reg, istat_next;
   logic [2:0]  imask_reg, imask_next;
   logic        wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic        irq_reg, irq_next;
   logic        pwr_reg, pwr_next;

   // Events from the sequencer
   logic       go_sgl, go_rpt, end_pass;
   logic       ev_sgl_begin, ev_rpt_begin, ev_sgl_done, ev_rpt_done;
   logic       pend_take, res_we, tick;
   logic [4:0] ev_chan;

   // Bus helpers
   logic        wr;
   logic [31:0] bm, wv, cw, rd_val, ctrl_rd;

   adcss_tick #(
      .DIV (UNIT_CYC)
   ) u_tick (
      .core_clk (core_clk),
      .rst      (rst),
      .ce       (ce),
      .clr      (state_reg != ADCSS_WAIT),
      .tick     (tick)
   );

   // Sequencer: delay, channel scan, conversion handshake
   always_comb begin
      state_next   = state_reg;
      chan_next    = chan_reg;
      pmask_next   = pmask_reg;
      dcnt_next    = dcnt_reg;
      req_next     = req_reg;
      req_next.start = 1'b0;
      psgl_next    = psgl_reg;
      go_sgl       = 1'b0;
      go_rpt       = 1'b0;
      end_pass     = 1'b0;
      ev_sgl_begin = 1'b0;
      ev_rpt_begin = 1'b0;
      ev_sgl_done  = 1'b0;
      ev_rpt_done  = 1'b0;
      ev_chan      = 5'h00;
      pend_take    = 1'b0;
      res_we       = 1'b0;
      case (state_reg)
         ADCSS_IDLE: begin
            if (act_reg && sgl_reg) begin
               go_sgl = 1'b1;
            end else if (act_reg && pend_reg) begin
               pend_take  = 1'b1;
               dcnt_next  = dly_reg[ADCSS_DLY_START_LSB +: ADCSS_DLY_W]; // RQ13
               state_next = ADCSS_WAIT;
            end
         end
         ADCSS_WAIT: begin
            if (!act_reg) begin
               state_next = ADCSS_IDLE;
            end else if (sgl_reg) begin
               go_sgl = 1'b1;
            end else if (!rpt_reg) begin
               state_next = ADCSS_IDLE;
            end else if (pend_reg) begin
               pend_take = 1'b1;
               dcnt_next = dly_reg[ADCSS_DLY_START_LSB +: ADCSS_DLY_W]; // RQ13
            end else if (dcnt_reg == 16'h0000) begin
               go_rpt = 1'b1; // RQ15
            end else if (tick) begin
               dcnt_next = dcnt_reg - 16'h0001; // RQ13
            end
         end
         ADCSS_ISSUE: begin
            if (chan_reg == 3'(ADCSS_NCH)) begin
               end_pass = 1'b1;
            end else if (pmask_reg[chan_reg]) begin
               req_next.start   = 1'b1;
               req_next.channel = chan_reg;
               state_next       = ADCSS_BUSY;
            end else begin
               chan_next = chan_reg + 3'h1;
            end
         end
         ADCSS_BUSY: begin
            if (conv_res.done) begin
               res_we            = 1'b1;
               ev_chan[chan_reg] = 1'b1; // RQ1
               chan_next         = chan_reg + 3'h1;
               state_next        = ADCSS_ISSUE;
            end
         end
         default: begin
            state_next = ADCSS_IDLE;
         end
      endcase
      if (go_sgl) begin
         ev_sgl_begin = 1'b1; // RQ14
         pmask_next   = smask_reg; // RQ5
         psgl_next    = 1'b1;
         chan_next    = 3'h0;
         state_next   = ADCSS_ISSUE; // RQ12
      end
      if (go_rpt) begin
         ev_rpt_begin = 1'b1;
         pmask_next   = rmask_reg; // RQ6
         psgl_next    = 1'b0;
         chan_next    = 3'h0;
         state_next   = ADCSS_ISSUE;
      end
      if (end_pass) begin
         if (psgl_reg) begin
            ev_sgl_done = 1'b1; // RQ3
         end else begin
            ev_rpt_done = 1'b1; // RQ4
         end
         if (act_reg && rpt_reg) begin
            dcnt_next  = dly_reg[ADCSS_DLY_RPT_LSB +: ADCSS_DLY_W]; // RQ13
            state_next = ADCSS_WAIT;
         end else begin
            state_next = ADCSS_IDLE;
         end
      end
      if (srst_reg) begin
         state_next     = ADCSS_IDLE;
         req_next.start = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= ADCSS_IDLE;
         chan_reg  <= 3'h0;
         pmask_reg <= ADCSS_RST_MASK;
         dcnt_reg  <= 16'h0000;
         req_reg   <= '0;
         psgl_reg  <= 1'b0;
      end else if (ce) begin
         state_reg <= state_next;
         chan_reg  <= chan_next;
         pmask_reg <= pmask_next;
         dcnt_reg  <= dcnt_next;
         req_reg   <= req_next;
         psgl_reg  <= psgl_next;
      end
   end

   // Registers and Avalon slave
   always_comb begin
      wr = avs_write && !wait_reg;
      bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      wv = avs_writedata & bm;
      ctrl_rd = {24'h00_0000, sdone_reg, rdone_reg, 1'b0, srst_reg,
                 pwd_reg, rpt_reg, sgl_reg, act_reg};
      cw = (ctrl_rd & ~bm) | wv;
      act_next   = act_reg;
      sgl_next   = sgl_reg;
      rpt_next   = rpt_reg;
      pwd_next   = pwd_reg;
      srst_next  = srst_reg;
      rdone_next = rdone_reg;
      sdone_next = sdone_reg;
      pend_next  = pend_reg;
      dly_next   = dly_reg;
      done_next  = done_reg;
      smask_next = smask_reg;
      rmask_next = rmask_reg;
      istat_next = istat_reg;
      imask_next = imask_reg;
      res_next   = res_reg;
      // Hardware clears first, so a software write or a hardware set wins
      if (end_pass && psgl_reg) begin
         sgl_next = 1'b0; // RQ12
      end
      if (pend_take) begin
         pend_next = 1'b0;
      end
      if (ev_sgl_begin) begin
         sdone_next = 1'b0; // RQ14
      end
      if (ev_rpt_begin) begin
         rdone_next = 1'b0;
      end
      if (wr) begin
         if (avs_address == ADCSS_OFS_CTRL) begin
            act_next  = cw[ADCSS_CTRL_ACT];
            sgl_next  = cw[ADCSS_CTRL_SGL]; // RQ12
            rpt_next  = cw[ADCSS_CTRL_RPT]; // RQ15
            pwd_next  = cw[ADCSS_CTRL_PWD];
            srst_next = cw[ADCSS_CTRL_SRST];
            if (cw[ADCSS_CTRL_RPT] && !rpt_reg) begin
               pend_next = 1'b1; // RQ15
            end
            if (wv[ADCSS_CTRL_SDONE]) begin
               sdone_next = 1'b0;
            end
            if (wv[ADCSS_CTRL_RDONE]) begin
               rdone_next = 1'b0;
            end
         end else if (avs_address == ADCSS_OFS_DELAY) begin
            dly_next = (dly_reg & ~bm) | wv;
         end else if (avs_address == ADCSS_OFS_DONE) begin
            done_next = done_reg & ~wv[4:0]; // RQ2
         end else if (avs_address == ADCSS_OFS_SINGLE) begin
            smask_next = (smask_reg & ~bm[4:0]) | wv[4:0]; // RQ5
         end else if (avs_address == ADCSS_OFS_REPEAT) begin
            rmask_next = (rmask_reg & ~bm[4:0]) | wv[4:0]; // RQ6
         end else if (avs_address == ADCSS_OFS_IRQ_STAT) begin
            istat_next = istat_reg & ~wv[2:0];
         end else if (avs_address == ADCSS_OFS_IRQ_MASK) begin
            imask_next = (imask_reg & ~bm[2:0]) | wv[2:0];
         end
      end
      // Hardware sets last
      done_next = done_next | ev_chan; // RQ1 RQ16
      if (ev_sgl_done) begin
         sdone_next = 1'b1; // RQ3
      end
      if (ev_rpt_done) begin
         rdone_next = 1'b1; // RQ4
      end
      if (res_we) begin
         res_next[chan_reg] = conv_res.data; // RQ17
      end
      istat_next[ADCSS_IRQ_SGL]  = istat_next[ADCSS_IRQ_SGL] | ev_sgl_done;
      istat_next[ADCSS_IRQ_RPT]  = istat_next[ADCSS_IRQ_RPT] | ev_rpt_done;
      istat_next[ADCSS_IRQ_CHAN] = istat_next[ADCSS_IRQ_CHAN] | (|ev_chan);
      // Read decode, unmapped reads return zero
      rd_val = 32'h0000_0000;
      if (avs_address == ADCSS_OFS_CTRL) begin
         rd_val = ctrl_rd;
      end else if (avs_address == ADCSS_OFS_DELAY) begin
         rd_val = dly_reg;
      end else if (avs_address == ADCSS_OFS_DONE) begin
         rd_val = {27'h000_0000, done_reg};
      end else if (avs_address == ADCSS_OFS_SINGLE) begin
         rd_val = {27'h000_0000, smask_reg};
      end else if (avs_address == ADCSS_OFS_REPEAT) begin
         rd_val = {27'h000_0000, rmask_reg};
      end else if (avs_address == ADCSS_OFS_IRQ_STAT) begin
         rd_val = {29'h0000_0000, istat_reg};
      end else if (avs_address == ADCSS_OFS_IRQ_MASK) begin
         rd_val = {29'h0000_0000, imask_reg};
      end
      for (int i = 0; i < ADCSS_NCH; i++) begin
         if (avs_address == ADCSS_OFS_RES0 + 6'(i) * ADCSS_RES_STRIDE) begin
            rd_val = {22'h00_0000, res_reg[i]}; // RQ7 RQ8 RQ9
         end
      end
      // One wait cycle, then waitrequest low for one cycle
      wait_next  = !((avs_read || avs_write) && wait_reg);
      rdata_next = rdata_reg;
      if (avs_read && wait_reg) begin
         rdata_next = rd_val; // RQ10
      end
      irq_next = |(istat_next & imask_next);
      pwr_next = act_next && (pwd_next || state_next != ADCSS_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         act_reg   <= 1'b0;
         sgl_reg   <= 1'b0;
         rpt_reg   <= 1'b0;
         pwd_reg   <= 1'b0;
         srst_reg  <= 1'b0;
         rdone_reg <= 1'b0;
         sdone_reg <= 1'b0;
         pend_reg  <= 1'b0;
         dly_reg   <= ADCSS_RST_DELAY;
         done_reg  <= ADCSS_RST_MASK;
         smask_reg <= ADCSS_RST_MASK;
         rmask_reg <= ADCSS_RST_MASK;
         istat_reg <= ADCSS_RST_IRQ;
         imask_reg <= ADCSS_RST_IRQ;
         for (int i = 0; i < ADCSS_NCH; i++) begin
            res_reg[i] <= ADCSS_RST_RES;
         end
         wait_reg  <= 1'b1;
         rdata_reg <= ADCSS_RST_RDATA;
         irq_reg   <= 1'b0;
         pwr_reg   <= 1'b0;
      end else if (ce) begin
         act_reg   <= act_next;
         sgl_reg   <= sgl_next;
         rpt_reg   <= rpt_next;
         pwd_reg   <= pwd_next;
         srst_reg  <= srst_next;
         rdone_reg <= rdone_next;
         sdone_reg <= sdone_next;
         pend_reg  <= pend_next;
         dly_reg   <= dly_next;
         done_reg  <= done_next;
         smask_reg <= smask_next;
         rmask_reg <= rmask_next;
         istat_reg <= istat_next;
         imask_reg <= imask_next;
         res_reg   <= res_next;
         wait_reg  <= wait_next;
         rdata_reg <= rdata_next;
         irq_reg   <= irq_next;
         pwr_reg   <= pwr_next;
      end
   end

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign conv_req        = req_reg;
   assign conv_power      = pwr_reg;
   assign irq             = irq_reg;
endmodule // adcss_top

// File: design/adcss_pkg.sv
// Package: constants and types of the converter channel, status and result block
package adcss_pkg;
   localparam int unsigned ADCSS_NCH    = 5;
   localparam int unsigned ADCSS_RES_W  = 10;
   localparam int unsigned ADCSS_AW     = 6;
   localparam int unsigned ADCSS_DLY_W  = 16;
   localparam int unsigned ADCSS_IRQ_W  = 3;

   // Register byte offsets
   localparam logic [5:0] ADCSS_OFS_CTRL     = 6'h00;
   localparam logic [5:0] ADCSS_OFS_DELAY    = 6'h04;
   localparam logic [5:0] ADCSS_OFS_DONE     = 6'h08;
   localparam logic [5:0] ADCSS_OFS_SINGLE   = 6'h0C;
   localparam logic [5:0] ADCSS_OFS_REPEAT   = 6'h10;
   localparam logic [5:0] ADCSS_OFS_RES0     = 6'h14;
   localparam logic [5:0] ADCSS_RES_STRIDE   = 6'h04;
   localparam logic [5:0] ADCSS_OFS_IRQ_STAT = 6'h28;
   localparam logic [5:0] ADCSS_OFS_IRQ_MASK = 6'h2C;

   // Control register fields
   localparam int unsigned ADCSS_CTRL_ACT   = 0;
   localparam int unsigned ADCSS_CTRL_SGL   = 1;
   localparam int unsigned ADCSS_CTRL_RPT   = 2;
   localparam int unsigned ADCSS_CTRL_PWD   = 3;
   localparam int unsigned ADCSS_CTRL_SRST  = 4;
   localparam int unsigned ADCSS_CTRL_RDONE = 6;
   localparam int unsigned ADCSS_CTRL_SDONE = 7;

   // Delay register fields
   localparam int unsigned ADCSS_DLY_START_LSB = 0;
   localparam int unsigned ADCSS_DLY_RPT_LSB   = 16;

   // Interrupt status and mask fields
   localparam int unsigned ADCSS_IRQ_SGL  = 0;
   localparam int unsigned ADCSS_IRQ_RPT  = 1;
   localparam int unsigned ADCSS_IRQ_CHAN = 2;

   // Values after reset
   localparam logic [31:0] ADCSS_RST_DELAY = 32'h0000_0000;
   localparam logic [4:0]  ADCSS_RST_MASK  = 5'h00;
   localparam logic [9:0]  ADCSS_RST_RES   = 10'h000;
   localparam logic [2:0]  ADCSS_RST_IRQ   = 3'h0;
   localparam logic [31:0] ADCSS_RST_RDATA = 32'h0000_0000;

   // Delay unit, 40 us, as cycles of the 10 MHz clock
   localparam longint unsigned ADCSS_CLK_HZ     = 10000000;
   localparam longint unsigned ADCSS_UNIT_NS    = 40000;
   localparam longint unsigned ADCSS_UNIT_CYC_L = ADCSS_UNIT_NS * ADCSS_CLK_HZ / 1000000000;
   localparam int unsigned     ADCSS_UNIT_CYC   =
      (ADCSS_UNIT_CYC_L < 1) ? 1 : 32'(ADCSS_UNIT_CYC_L);

   typedef enum logic [1:0] {
      ADCSS_IDLE  = 2'b00,
      ADCSS_WAIT  = 2'b01,
      ADCSS_ISSUE = 2'b10,
      ADCSS_BUSY  = 2'b11
   } adcss_state_t;

   typedef struct packed {
      logic       start;
      logic [2:0] channel;
   } adcss_conv_req_t;

   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } adcss_conv_res_t;
endpackage

// File: design/adcss_tick.sv
// Unit tick divider for the start and repeat delays
module adcss_tick
   import adcss_pkg::*;
#(
   parameter int unsigned DIV = ADCSS_UNIT_CYC
) (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic clr,
   output logic      tick
);
   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic          tick_reg;
   logic          tick_next;

   always_comb begin
      cnt_next  = cnt_reg;
      tick_next = 1'b0;
      if (clr) begin
         cnt_next = '0;
      end else if (cnt_reg == LAST) begin
         cnt_next  = '0;
         tick_next = 1'b1;
      end else begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cnt_reg  <= '0;
         tick_reg <= 1'b0;
      end else if (ce) begin
         cnt_reg  <= cnt_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;
endmodule // adcss_tick

// File: tb/adcss_core_model.sv
// Behavioural model of the converter core behind the channel block
module adcss_core_model
   import adcss_pkg::*;
(
   input  wire logic            core_clk,
   input  wire logic            rst,
   input  wire adcss_conv_req_t conv_req,
   input  wire logic [7:0]      lat,
   input  wire logic [9:0]      base,
   output adcss_conv_res_t      conv_res
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       busy;
   logic [7:0] cnt;
   logic [2:0] ch;

   // One conversion at a time, answer lat+1 cycles after the start is taken
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy          <= 1'b0;
         cnt           <= 8'h00;
         ch            <= 3'h0;
         conv_res.done <= 1'b0;
         conv_res.data <= 10'h000;
      end else begin
         conv_res.done <= 1'b0;
         // Data is garbage outside the done pulse
         conv_res.data <= ~conv_res.data;
         if (conv_req.start) begin
            busy <= 1'b1;
            cnt  <= lat;
            ch   <= conv_req.channel;
         end else if (busy) begin
            if (cnt == 8'h00) begin
               conv_res.done <= 1'b1;
               conv_res.data <= base + {7'h00, ch};
               busy          <= 1'b0;
            end else begin
               cnt <= cnt - 8'h01;
            end
         end
      end
   end
endmodule // adcss_core_model

// File: tb/adcss_top_assertions.sv
// Port checker for the converter channel, status and result block
module adcss_chk
   import adcss_pkg::*;
#(
   parameter int unsigned UNIT_CYC = ADCSS_UNIT_CYC
) (
   input wire logic            core_clk,
   input wire logic            rst,
   input wire logic            ce,
   input wire logic [5:0]      avs_address,
   input wire logic            avs_read,
   input wire logic            avs_write,
   input wire logic [31:0]     avs_writedata,
   input wire logic [3:0]      avs_byteenable,
   input wire logic [31:0]     avs_readdata,
   input wire logic            avs_waitrequest,
   input wire adcss_conv_req_t conv_req,
   input wire adcss_conv_res_t conv_res,
   input wire logic            conv_power,
   input wire logic            irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic outst;
   always_ff @(posedge core_clk) begin
      if (rst) outst <= 1'b0;
      else if (conv_req.start) outst <= 1'b1;
      else if (conv_res.done) outst <= 1'b0;
   end

   sequence s_rd(logic sel);
      (avs_read && avs_waitrequest && sel) ##1 !avs_waitrequest;
   endsequence
   logic unmapped;
   assign unmapped = (avs_address[1:0] != 2'b00) || (avs_address > 6'h2C);

   a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=>
      !avs_waitrequest) else $error("waitrequest not answered in one cycle");
   a_wait_low_short: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_start_one_pulse: assert property (conv_req.start |=> !conv_req.start)
      else $error("start pulse longer than one cycle");
   a_start_chan_range: assert property (conv_req.start |-> conv_req.channel < 3'h5)
      else $error("start for a channel beyond four");
   a_single_outstanding: assert property (conv_req.start |-> !outst)
      else $error("second conversion while one outstanding");
   a_gap_after_done: assert property (conv_res.done |=> !conv_req.start)
      else $error("start too soon after done");
   a_unmapped_zero: assert property (s_rd(unmapped) |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_result_upper_zero: assert property (s_rd(avs_address >= 6'h14 && avs_address <= 6'h24)
      |-> avs_readdata[31:10] == 22'h0) else $error("result upper bits not zero");
   a_flags_upper_zero: assert property (s_rd(avs_address inside {6'h08, 6'h0C, 6'h10})
      |-> avs_readdata[31:5] == 27'h0) else $error("flag or mask upper bits not zero");
   a_readdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read) &&
      $past(avs_waitrequest)) else $error("read data changed without a read");
endmodule // adcss_chk

bind adcss_top adcss_chk #(.UNIT_CYC(UNIT_CYC)) u_chk (
   .core_clk(core_clk), .rst(rst), .ce(ce), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .conv_req(conv_req), .conv_res(conv_res),
   .conv_power(conv_power), .irq(irq));

// File: tb/adcss_top_bench.sv
// Self-checking bench of the converter channel, status and result block
module adcss_top_bench
   import adcss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int UNIT = 4;
   typedef struct {logic [4:0] mask; logic [9:0] base; logic [7:0] lat;} adcss_row_t;

   logic            core_clk, rst, ce, avs_read, avs_write, irq, conv_power;
   logic [5:0]      avs_address;
   logic [31:0]     avs_writedata, avs_readdata, q;
   logic [3:0]      avs_byteenable;
   logic            avs_waitrequest;
   adcss_conv_req_t conv_req;
   adcss_conv_res_t conv_res;
   logic [7:0]      lat;
   logic [9:0]      base;
   logic [9:0]      exp_res [5];
   int              fails, num_checks, n;
   adcss_row_t rows [4] = '{'{5'h01, 10'h155, 8'h00}, '{5'h1F, 10'h3F0, 8'h05},
                            '{5'h0A, 10'h2AA, 8'h20}, '{5'h00, 10'h001, 8'h01}};

   adcss_top #(.UNIT_CYC(UNIT)) dut (.core_clk(core_clk), .rst(rst), .ce(ce),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .conv_req(conv_req), .conv_res(conv_res), .conv_power(conv_power), .irq(irq));
   adcss_core_model u_core (.core_clk(core_clk), .rst(rst), .conv_req(conv_req),
      .lat(lat), .base(base), .conv_res(conv_res));

   always #50 core_clk = ~core_clk;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   // Avalon master: hold request until waitrequest sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask

   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask

   task automatic wait_ctrl(input int b, input logic v);
      do begin
         bus(1'b0, ADCSS_OFS_CTRL, 32'h0);
      end while (q[b] !== v);
   endtask

   initial begin
      core_clk = 1'b0;
      repeat (20000) @(posedge core_clk);
      fails++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      lat = 8'h00;
      base = 10'h000;
      for (int i = 0; i < 5; i++) exp_res[i] = 10'h000;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      // Full-word reads of every register from 0x00 to 0x2C, all zero after reset
      for (int a = 0; a <= 6'h2C; a += 4) rdc(6'(a), 32'h0);
      // Masks are not touched while a cycle runs
      foreach (rows[r]) begin
         base <= rows[r].base;
         lat <= rows[r].lat;
         bus(1'b1, ADCSS_OFS_SINGLE, {27'h0, rows[r].mask});
         bus(1'b1, ADCSS_OFS_CTRL, 32'h0000_0003);
         wait_ctrl(ADCSS_CTRL_SGL, 1'b0);
         chk(q & 32'h80, 32'h80);
         rdc(ADCSS_OFS_DONE, {27'h0, rows[r].mask});
         for (int c = 0; c < 5; c++) begin
            if (rows[r].mask[c]) exp_res[c] = rows[r].base + 10'(c);
            rdc(ADCSS_OFS_RES0 + 6'(4 * c), {22'h0, exp_res[c]});
         end
         bus(1'b1, ADCSS_OFS_DONE, 32'h0000_0005);
         rdc(ADCSS_OFS_DONE, {27'h0, rows[r].mask & 5'h1A});
         bus(1'b1, ADCSS_OFS_DONE, 32'h0000_001F);
         rdc(ADCSS_OFS_DONE, 32'h0);
      end
      // Unmapped places and read-only result
      rdc(6'h30, 32'h0);
      rdc(6'h09, 32'h0);
      bus(1'b1, ADCSS_OFS_RES0, 32'hFFFF_FFFF);
      rdc(ADCSS_OFS_RES0, {22'h0, exp_res[0]});
      // Slow conversion: single done cleared as the cycle begins
      lat <= 8'hC8;
      bus(1'b1, ADCSS_OFS_SINGLE, 32'h0000_0001);
      bus(1'b1, ADCSS_OFS_CTRL, 32'h0000_0003);
      rdc(ADCSS_OFS_CTRL, 32'h0000_0003);
      wait_ctrl(ADCSS_CTRL_SDONE, 1'b1);
      lat <= 8'h00;
      exp_res[0] = rows[3].base;
      bus(1'b1, ADCSS_OFS_SINGLE, 32'h0000_0002);
      bus(1'b1, ADCSS_OFS_CTRL, 32'h0000_0003);
      wait_ctrl(ADCSS_CTRL_SGL, 1'b0);
      rdc(ADCSS_OFS_DONE, 32'h0000_0003);
      // Interrupt status, mask and clear
      rdc(ADCSS_OFS_IRQ_STAT, 32'h0000_0005);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, ADCSS_OFS_IRQ_MASK, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b1, ADCSS_OFS_IRQ_STAT, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, ADCSS_OFS_IRQ_STAT, 32'h0000_0001);
      rdc(ADCSS_OFS_IRQ_STAT, 32'h0);
      // Repeat mode with start delay of two units
      bus(1'b1, ADCSS_OFS_DONE, 32'h0000_001F);
      lat <= 8'h02;
      base <= 10'h200;
      bus(1'b1, ADCSS_OFS_DELAY, 32'h0001_0002);
      bus(1'b1, ADCSS_OFS_REPEAT, 32'h0000_0012);
      bus(1'b1, ADCSS_OFS_CTRL, 32'h0000_0005);
      // Frozen clock enable must hold the start delay
      ce <= 1'b0;
      repeat (30) @(posedge core_clk);
      ce <= 1'b1;
      n = 0;
      while (conv_req.start !== 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      chk(32'(n >= 2 * UNIT && n < 2 * UNIT + 20), 32'h1);
      wait_ctrl(ADCSS_CTRL_RDONE, 1'b1);
      rdc(ADCSS_OFS_DONE, 32'h0000_0012);
      rdc(ADCSS_OFS_RES0 + 6'h10, 32'h0000_0204);
      bus(1'b1, ADCSS_OFS_CTRL, 32'h0000_0041);
      repeat (100) @(posedge core_clk);
      rdc(ADCSS_OFS_RES0, {22'h0, exp_res[0]});
      stop_test();
   end
endmodule // adcss_top_bench
